// *** core/irpc_consts.vh ***
// Constants for the infrared pulse codec
// Behaviour
// - Receive pulses shorter than 1.41 us ignored
// - Config bit 0 sets receive polarity
// - Config bit 1 sets transmit polarity
// - 115k pulse 1.6 us, 1.41 to 2.71
// - Rates 2.4k to 115k supported
// - Pulse widens with bit period, max 88.55
// - ASK carrier 1 us on, 1 us off
// - ASK receive outputs reproduce carrier bursts
// - Pin inversion inverts again
// - Standard 115k format, 2400 available
`ifndef IRPC_CONSTS_VH
`define IRPC_CONSTS_VH
`define IRPC_CLK_MHZ        100
`define IRPC_RX_MIN_NS      1410
`define IRPC_RX_MIN_CYC     ((`IRPC_RX_MIN_NS * `IRPC_CLK_MHZ + 999) / 1000)
`define IRPC_TX_115K_NS     1600
`define IRPC_TX_115K_CYC    ((`IRPC_TX_115K_NS * `IRPC_CLK_MHZ) / 1000)
`define IRPC_CARRIER_NS     1000
`define IRPC_CARRIER_CYC    ((`IRPC_CARRIER_NS * `IRPC_CLK_MHZ) / 1000)
`define IRPC_CFG_RXPOL_BIT  0
`define IRPC_CFG_TXPOL_BIT  1
`define IRPC_CFG_RESET      2'h2
`define IRPC_CNT_W          16
`define IRPC_BUF_W          1
`endif

// *** core/irpc_skid_buffer.v ***
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`include "irpc_consts.vh"
module irpc_skid_buffer (
  input  wire                   clk_sys,
  input  wire                   sys_rst,
  input  wire                   inValid,
  output wire                   inReady,
  input  wire [`IRPC_BUF_W-1:0] inData,
  output wire                   outValid,
  input  wire                   outReady,
  output wire [`IRPC_BUF_W-1:0] outData
);
  reg [`IRPC_BUF_W-1:0] mem_q [0:1];
  reg                   wrPtr_q;
  reg                   rdPtr_q;
  reg [1:0]             count_q;
  wire                  doWr;
  wire                  doRd;

  assign inReady  = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData  = mem_q[rdPtr_q];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always @(posedge clk_sys) begin
    if (doWr) begin
      mem_q[wrPtr_q] <= inData;
    end
    if (sys_rst) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (doWr) begin
        wrPtr_q <= ~wrPtr_q;
      end
      if (doRd) begin
        rdPtr_q <= ~rdPtr_q;
      end
      if (doWr && !doRd) begin
        count_q <= count_q + 2'h1;
      end else if (doRd && !doWr) begin
        count_q <= count_q - 2'h1;
      end
    end
  end
endmodule // irpc_skid_buffer

// *** core/irpc_infrared_pulse_codec.v ***
// Infrared pulse codec: UART bit stream to and from optical pulses
`timescale 1ns/1ps
`include "irpc_consts.vh"
module irpc_infrared_pulse_codec (
  input  wire                  clk_sys,
  input  wire                  sys_rst,
  input  wire [1:0]            irConfigRegister,
  input  wire                  gpioInvert,
  input  wire                  askMode,
  input  wire [`IRPC_CNT_W-1:0] bitPeriodCycles,
  input  wire                  txBitValid,
  output wire                  txBitReady,
  input  wire                  txBit,
  output reg                   rxBit,
  output reg                   rxBitValid,
  input  wire                  ir_receive_in,
  output reg                   ir_transmit_out,
  output reg                   ir_transmit_out_inverted,
  output reg                   modulated_transmit_out,
  output reg                   modulated_transmit_out_inverted,
  output reg                   modulated_receive_out,
  output reg                   modulated_receive_out_inverted
);
  localparam ST_IDLE = 2'h0;
  localparam ST_BIT  = 2'h1;
  localparam [`IRPC_CNT_W-1:0] TX_MIN_CYC   = `IRPC_TX_115K_CYC;
  localparam [`IRPC_CNT_W-1:0] RX_LAST_CYC  = `IRPC_RX_MIN_CYC - 1;
  localparam [`IRPC_CNT_W-1:0] CAR_LAST_CYC = `IRPC_CARRIER_CYC - 1;

  reg  [1:0]             state_q;
  reg  [`IRPC_CNT_W-1:0] bitCnt_q;
  reg                    curBit_q;
  reg  [`IRPC_CNT_W-1:0] carCnt_q;
  reg                    carPhase_q;
  reg  [2:0]             rxSync_q;
  reg                    rxStable_q;
  reg  [`IRPC_CNT_W-1:0] rxCnt_q;
  reg                    rxSeen_q;
  reg  [`IRPC_CNT_W-1:0] rxBitCnt_q;
  wire                   bufValid;
  wire                   bufData;
  wire                   takeBit;
  wire                   txActive;
  wire                   txLevel;
  wire                   rxActive;
  wire                   rxDetNow;
  wire [`IRPC_CNT_W-1:0] pulseCycles;

  // Nominal width is 3/16 of a bit, never less than the 1.6 us (160-cycle) minimum; at 115k 3/16 is used
  function [`IRPC_CNT_W-1:0] pulse_len;
    input [`IRPC_CNT_W-1:0] period;
    reg   [`IRPC_CNT_W+1:0] w;
    begin
      w = ({2'h0, period} * 18'h3) >> 4;
      if (w[`IRPC_CNT_W-1:0] < TX_MIN_CYC)
        pulse_len = TX_MIN_CYC;
      else
        pulse_len = w[`IRPC_CNT_W-1:0];
    end
  endfunction

  assign pulseCycles = pulse_len(bitPeriodCycles);

  // Buffer keeps a bit if the encoder is busy when the UART offers it
  irpc_skid_buffer uBuf (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .inValid (txBitValid),
    .inReady (txBitReady),
    .inData  (txBit),
    .outValid(bufValid),
    .outReady(takeBit),
    .outData (bufData)
  );

  assign takeBit = (state_q == ST_IDLE) && bufValid;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q    <= ST_IDLE;
      bitCnt_q   <= {`IRPC_CNT_W{1'b0}};
      curBit_q   <= 1'b1;
      carCnt_q   <= {`IRPC_CNT_W{1'b0}};
      carPhase_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (bufValid) begin
            curBit_q   <= bufData;
            bitCnt_q   <= {`IRPC_CNT_W{1'b0}};
            carCnt_q   <= {`IRPC_CNT_W{1'b0}};
            carPhase_q <= 1'b1;
            state_q    <= ST_BIT;
          end
        end
        ST_BIT: begin
          if (carCnt_q == CAR_LAST_CYC) begin
            carCnt_q   <= {`IRPC_CNT_W{1'b0}};
            carPhase_q <= ~carPhase_q;
          end else begin
            carCnt_q <= carCnt_q + 1'b1;
          end
          if (bitCnt_q >= bitPeriodCycles - 1'b1) begin
            state_q <= ST_IDLE;
          end else begin
            bitCnt_q <= bitCnt_q + 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Zero bit is the marked one; one bit leaves the line idle
  assign txActive = (state_q == ST_BIT) && !curBit_q;
  assign txLevel  = askMode ? (txActive && carPhase_q)
                            : (txActive && bitCnt_q < pulseCycles);

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ir_transmit_out                 <= 1'b0;
      ir_transmit_out_inverted        <= 1'b1;
      modulated_transmit_out          <= 1'b0;
      modulated_transmit_out_inverted <= 1'b1;
    end else begin
      // Active-low when bit set, then pin inversion on top
      ir_transmit_out <= (askMode ? 1'b0 : txLevel)
        ^ irConfigRegister[`IRPC_CFG_TXPOL_BIT] ^ gpioInvert;
      ir_transmit_out_inverted <= ~((askMode ? 1'b0 : txLevel)
        ^ irConfigRegister[`IRPC_CFG_TXPOL_BIT] ^ gpioInvert);
      modulated_transmit_out <= (askMode ? txLevel : 1'b0)
        ^ irConfigRegister[`IRPC_CFG_TXPOL_BIT] ^ gpioInvert;
      modulated_transmit_out_inverted <= ~((askMode ? txLevel : 1'b0)
        ^ irConfigRegister[`IRPC_CFG_TXPOL_BIT] ^ gpioInvert);
    end
  end

  // Receive side: three-stage sync, change accepted when stages 2 and 3 agree
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rxSync_q   <= 3'h0;
      rxStable_q <= 1'b0;
    end else begin
      rxSync_q <= {rxSync_q[1:0], ir_receive_in};
      if (rxSync_q[1] == rxSync_q[2]) begin
        rxStable_q <= rxSync_q[2];
      end
    end
  end

  assign rxActive = rxStable_q ^ irConfigRegister[`IRPC_CFG_RXPOL_BIT]
                    ^ gpioInvert;
  assign rxDetNow = rxActive && (rxCnt_q == RX_LAST_CYC);

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rxCnt_q                        <= {`IRPC_CNT_W{1'b0}};
      rxSeen_q                       <= 1'b0;
      rxBitCnt_q                     <= {`IRPC_CNT_W{1'b0}};
      rxBit                          <= 1'b1;
      rxBitValid                     <= 1'b0;
      modulated_receive_out          <= 1'b0;
      modulated_receive_out_inverted <= 1'b1;
    end else begin
      modulated_receive_out          <= askMode & rxActive;
      modulated_receive_out_inverted <= ~(askMode & rxActive);
      rxBitValid <= 1'b0;
      if (rxActive) begin
        if (rxCnt_q != {`IRPC_CNT_W{1'b1}}) begin
          rxCnt_q <= rxCnt_q + 1'b1;
        end
      end else begin
        rxCnt_q <= {`IRPC_CNT_W{1'b0}};
      end
      if (rxDetNow) begin
        rxSeen_q <= 1'b1;
      end
      // One decision per bit period; several detections in one period count as one
      if (rxBitCnt_q >= bitPeriodCycles - 1'b1) begin
        rxBitCnt_q <= {`IRPC_CNT_W{1'b0}};
        // Detection on the window's last cycle must not be lost
        rxBit      <= ~(rxSeen_q | rxDetNow);
        rxBitValid <= 1'b1;
        rxSeen_q   <= 1'b0;
      end else begin
        rxBitCnt_q <= rxBitCnt_q + 1'b1;
      end
    end
  end
endmodule // irpc_infrared_pulse_codec

// *** verification/irpc_chk_sva.sv ***
// Port assertions for the infrared pulse codec
`timescale 1ns/1ps
module irpc_chk (
  input wire        clk_sys,
  input wire        sys_rst,
  input wire [1:0]  irConfigRegister,
  input wire        gpioInvert,
  input wire        askMode,
  input wire [15:0] bitPeriodCycles,
  input wire        rxBitValid,
  input wire        ir_receive_in,
  input wire        ir_transmit_out,
  input wire        ir_transmit_out_inverted,
  input wire        modulated_transmit_out,
  input wire        modulated_transmit_out_inverted,
  input wire        modulated_receive_out,
  input wire        modulated_receive_out_inverted
);
  reg         txPol_q;
  wire        txAct = ir_transmit_out ^ txPol_q;
  wire        mAct = modulated_transmit_out ^ txPol_q;
  wire        rxAct = ir_receive_in ^ irConfigRegister[0] ^ gpioInvert;
  reg  [15:0] tRun_q, mRun_q, gap_q;
  always @(posedge clk_sys) begin
    // Registered outputs follow a polarity change one edge late
    txPol_q <= irConfigRegister[1] ^ gpioInvert;
    tRun_q <= (sys_rst || !txAct) ? 16'h0 : tRun_q + 16'h1;
    mRun_q <= (sys_rst || !mAct) ? 16'h0 : mRun_q + 16'h1;
    gap_q <= (sys_rst || rxBitValid) ? {15'h0, rxBitValid} : gap_q + {15'h0, gap_q != 16'h0};
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_tx_pair: assert property (ir_transmit_out_inverted != ir_transmit_out)
    else $error("tx pair");
  a_mtx_pair: assert property (modulated_transmit_out_inverted != modulated_transmit_out)
    else $error("carrier pair");
  a_mrx_pair: assert property (modulated_receive_out_inverted != modulated_receive_out)
    else $error("rx copy pair");
  a_strobe_single: assert property (rxBitValid |=> !rxBitValid)
    else $error("long strobe");
  a_bit_window: assert property (rxBitValid && gap_q != 16'h0 |-> gap_q == bitPeriodCycles)
    else $error("strobe spacing");
  // Bound fits the top rate only, which is all this bench runs
  a_tx_width: assert property (!askMode && $fell(txAct) |-> tRun_q inside {[16'h8d:16'h10f]})
    else $error("tx width");
  a_carrier_on: assert property (askMode && $fell(mAct) |-> mRun_q <= 16'h78)
    else $error("carrier on long");
  a_rx_copy: assert property ((askMode && rxAct) [*6] |-> modulated_receive_out)
    else $error("rx copy");
endmodule // irpc_chk

// *** verification/irpc_ir_xcvr.sv ***
// Infrared transceiver model: times tx pulses, sends rx pulses
`timescale 1ns/1ps
module irpc_ir_xcvr (
  input  wire clk_sys,
  input  wire txLine,
  input  wire txLow,
  input  wire rxLow,
  output wire rxLine
);
  int widths[$];
  int run = 0;
  reg act = 1'b0;
  // Always driven; idle sits at the inactive level
  assign rxLine = act ^ rxLow;
  always @(posedge clk_sys) begin
    if ((txLine ^ txLow) === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      widths.push_back(run);
      run <= 0;
    end
  end
  task automatic pulse(int w);
    @(negedge clk_sys);
    act = 1'b1;
    repeat (w) @(negedge clk_sys);
    act = 1'b0;
  endtask
endmodule // irpc_ir_xcvr

// *** verification/irpc_infrared_pulse_codec_tb.sv ***
// Self-checking bench for the infrared pulse codec
`timescale 1ns/1ps
module irpc_infrared_pulse_codec_tb;
  reg clk_sys = 0, sys_rst = 1, gpioInvert = 0, askMode = 0, txBitValid = 0, txBit = 1;
  reg [1:0] irConfigRegister = 2'h0;
  reg [15:0] bitPeriodCycles = 16'h364;
  reg [31:0] rng = 32'hcf17;
  wire txBitReady, rxBit, rxBitValid, ir_receive_in, ir_transmit_out, ir_transmit_out_inverted;
  wire modulated_transmit_out, modulated_transmit_out_inverted;
  wire modulated_receive_out, modulated_receive_out_inverted;
  int n_fail = 0, n_tests = 0, zeros, rises, z, longs, mrx;
  always #5 clk_sys = ~clk_sys;
  irpc_infrared_pulse_codec DUT (.*);
  irpc_ir_xcvr X (.clk_sys, .txLine(ir_transmit_out), .txLow(irConfigRegister[1] ^ gpioInvert),
    .rxLow(irConfigRegister[0] ^ gpioInvert), .rxLine(ir_receive_in));
  always @(posedge clk_sys) begin
    if (rxBitValid === 1'b1 && rxBit === 1'b0) zeros++;
    if (askMode && $rose(modulated_transmit_out ^ irConfigRegister[1] ^ gpioInvert)) rises++;
    if (askMode && modulated_receive_out === 1'b1) mrx++;
  end
  function automatic logic nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[0];
  endfunction
  task automatic chk(string n, int lo, int hi, logic [31:0] g);
    n_tests++;
    if ($isunknown(g) || g < lo || g > hi) begin
      n_fail++;
      $display("BAD %s exp %0d..%0d got %0d", n, lo, hi, g);
    end
  endtask
  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic put(logic b);
    int k = 0;
    z += !b;
    @(negedge clk_sys);
    txBit = b;
    txBitValid = 1;
    while (txBitReady !== 1'b1 && k++ < 3000) @(negedge clk_sys);
    if (k > 3000) n_fail++;
    @(posedge clk_sys);
  endtask
  task automatic drain(int n);
    @(negedge clk_sys);
    txBitValid = 0;
    repeat (n * bitPeriodCycles + 20) @(negedge clk_sys);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 0;
    for (int c = 0; c < 4; c++) begin
      irConfigRegister = c[1:0];
      gpioInvert = c[0] ^ c[1];
      // Outputs follow a polarity change one edge late; let it settle
      repeat (4) @(negedge clk_sys);
      z = 0;
      X.widths.delete();
      for (int i = 0; i < 6; i++) begin
        put(nxt());
        if (i == 2) begin
          // Encoder busy, two bits queued: the buffer must refuse
          @(negedge clk_sys);
          txBitValid = 0;
          chk("txBitReady", 0, 0, txBitReady);
        end
      end
      drain(3);
      chk("txPulses", z, z, X.widths.size());
      foreach (X.widths[j]) chk("txWidth", 141, 271, X.widths[j]);
      zeros = 0;
      longs = 0;
      for (int i = 0; i < 4; i++) begin
        longs += i % 2;
        X.pulse(140 + i % 2);
        repeat (1800 + nxt() * 50) @(negedge clk_sys);
      end
      chk("rxZeros", longs, longs, zeros);
    end
    askMode = 1;
    rises = 0;
    mrx = 0;
    put(1'b0);
    drain(2);
    X.pulse(300);
    repeat (8) @(negedge clk_sys);
    chk("mrxCycles", 300, 300, mrx);
    chk("carrierOn", (bitPeriodCycles + 199) / 200, (bitPeriodCycles + 199) / 200, rises);
    final_report;
  end
  initial begin
    #900000;
    n_fail++;
    final_report;
  end
endmodule // irpc_infrared_pulse_codec_tb
bind irpc_infrared_pulse_codec irpc_chk CHK (.*);
